// ---- design/i2c_master_write_sequencer.sv ----
// Function
// - Enabled with transmit interrupts on and no data, the interrupt rises with transmit-empty.
// - With start set, drive START then move the data byte into the shifter.
// - After the first bit of a loaded byte, assert transmit-empty.
// - In each acknowledge clock sample SDA with SCL high; low sets acknowledge.
// - High acknowledge with no start or stop pending sets nack flag, clears acknowledge.
// - Stop after a nack drives STOP, then clears stop bit and nack flag.
// - After an acknowledged address load and shift the next data byte.
// - With stop or start pending, no nack interrupt in the final slot.
// - After the last acknowledge slot emit STOP or repeated START, clear that bit.
// - Stop bit stays set until STOP has been driven, then clears; set while idle with no start, it clears without a STOP.
// - After a probe acknowledge reads one if acknowledged, zero if not.
// - On an acknowledged first 10-bit byte, load and shift the second byte.
// - A nack on the second 10-bit byte or data sets nack, clears acknowledge.
// - With no data and no start or stop, stall at the acknowledge clock.
// - Each data write clears transmit-empty.
// - Flush discards pending transmit data so transmit-empty returns.
`timescale 1ns/100ps
module i2c_master_write_sequencer import i2c_wseq_pkg::*; #(
  parameter int QTR = QTR_CYCLES,
  parameter int DEPTH = TX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control bits
  input wire logic controller_enable_bit_in,
  input wire logic transmit_irq_enable_in,
  input wire logic start_set_in,
  input wire logic stop_set_in,
  input wire logic flush_set_in,
  // Transmit data
  input wire logic tx_wr_in,
  input wire logic [BYTE_BITS-1:0] tx_data_in,
  output logic tx_ready_out,
  // Status bits
  output logic start_bit_out,
  output logic stop_bit_out,
  output logic tx_data_empty_flag_out,
  output logic nack_irq_flag_out,
  output logic ack_out,
  output logic busy_out,
  output logic irq_out,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out
);

  seq_state_t state;
  seq_state_t next_state;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic [2:0] bitn;
  logic [2:0] next_bitn;
  logic [BYTE_BITS-1:0] shift;
  logic [BYTE_BITS-1:0] next_shift;
  bus_lines_t lines;
  bus_lines_t next_lines;
  logic first_done;
  logic pop;
  logic ev_first;
  logic ev_ack_slot;
  logic ev_nack;
  logic ev_started;
  logic ev_stopped;
  logic fifo_valid;
  logic fifo_has;
  logic [BYTE_BITS-1:0] fifo_data;
  logic tick;

  wire en = controller_enable_bit_in;
  wire start_bit = start_bit_out;
  wire stop_bit = stop_bit_out;
  wire wr_take = tx_wr_in && tx_ready_out;
  wire end_pending = start_bit || stop_bit;

  tx_fifo #(.WIDTH(BYTE_BITS), .DEPTH(DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .in_valid_in(tx_wr_in),
    .in_data_in(tx_data_in),
    .in_ready_out(tx_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(pop),
    .flush_in(flush_set_in),
    .has_data_out(fifo_has)
  );

  scl_quarter_tick #(.CYCLES(QTR)) u_tick (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(en),
    .tick_out(tick)
  );

  // The sequencer moves one quarter phase per tick and sets the line levels
  // for the phase that it enters.
  always_comb begin
    next_state = state;
    next_ph = ph;
    next_bitn = bitn;
    next_shift = shift;
    next_lines = lines;
    pop = 1'h0;
    ev_first = 1'h0;
    ev_ack_slot = 1'h0;
    ev_nack = 1'h0;
    ev_started = 1'h0;
    ev_stopped = 1'h0;
    if (!en) begin
      next_state = ST_IDLE;
      next_ph = PH_FALL;
      next_lines = LINES_IDLE;
    end else if (tick) begin
      next_ph = ph + 2'h1;
      unique case (state)
        ST_IDLE: begin
          next_ph = PH_FALL;
          if (stop_bit && !start_bit) begin
            ev_stopped = 1'h1;
          end else if (start_bit && fifo_valid) begin
            next_state = ST_START;
          end
        end
        ST_START: begin
          if (ph == PH_SET) begin
            next_lines.sda = LINE_LOW;
          end
          if (ph == PH_LAST) begin
            ev_started = 1'h1;
            pop = 1'h1;
            next_shift = fifo_data;
            next_bitn = BIT_MSB;
            next_state = ST_BIT;
            next_lines.scl = LINE_LOW;
          end
        end
        ST_BIT: begin
          if (ph == PH_FALL) begin
            next_lines.sda = shift[BYTE_BITS-1];
          end
          if (ph == PH_SET) begin
            next_lines.scl = LINE_REL;
          end
          if (ph == PH_LAST) begin
            ev_first = bitn == BIT_MSB;
            next_lines.scl = LINE_LOW;
            next_shift = shift << 1;
            next_bitn = bitn - 3'h1;
            if (bitn == BIT_LSB) begin
              next_state = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (ph == PH_FALL) begin
            next_lines.sda = LINE_REL;
            if (!fifo_has && !end_pending) begin
              next_ph = PH_FALL;
            end
          end
          if (ph == PH_SET) begin
            next_lines.scl = LINE_REL;
          end
          if (ph == PH_RISE) begin
            ev_ack_slot = 1'h1;
            ev_nack = sda_in && !end_pending;
          end
          if (ph == PH_LAST) begin
            next_lines.scl = LINE_LOW;
            if (stop_bit) begin
              next_state = ST_STOP;
            end else if (start_bit) begin
              next_state = ST_RESTART;
            end else if (nack_irq_flag_out || !fifo_valid) begin
              next_state = ST_HOLD;
            end else begin
              pop = 1'h1;
              next_shift = fifo_data;
              next_bitn = BIT_MSB;
              next_state = ST_BIT;
            end
          end
        end
        ST_HOLD: begin
          next_ph = PH_FALL;
          if (stop_bit) begin
            next_state = ST_STOP;
          end else if (start_bit) begin
            next_state = ST_RESTART;
          end else if (!nack_irq_flag_out && fifo_valid) begin
            pop = 1'h1;
            next_shift = fifo_data;
            next_bitn = BIT_MSB;
            next_state = ST_BIT;
          end
        end
        ST_STOP: begin
          if (ph == PH_FALL) begin
            next_lines.sda = LINE_LOW;
          end
          if (ph == PH_SET) begin
            next_lines.scl = LINE_REL;
          end
          if (ph == PH_LAST) begin
            next_lines.sda = LINE_REL;
            ev_stopped = 1'h1;
            next_state = ST_IDLE;
          end
        end
        ST_RESTART: begin
          if (ph == PH_FALL) begin
            next_lines.sda = LINE_REL;
          end
          if (ph == PH_SET) begin
            next_lines.scl = LINE_REL;
          end
          if (ph == PH_LAST) begin
            next_state = ST_IDLE;
          end
        end
      endcase
    end
  end

  wire tx_data_empty_flag_set = en && !fifo_has && !wr_take
      && (state == ST_IDLE || first_done || ev_first);
  wire next_irq = en && ((transmit_irq_enable_in && tx_data_empty_flag_out)
      || nack_irq_flag_out);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      ph <= PH_FALL;
      bitn <= BIT_MSB;
      shift <= '0;
      lines <= LINES_IDLE;
      first_done <= 1'h0;
    end else begin
      state <= next_state;
      ph <= next_ph;
      bitn <= next_bitn;
      shift <= next_shift;
      lines <= next_lines;
      first_done <= pop ? 1'h0 : (first_done || ev_first);
    end
  end

  // Software sets always win over a hardware clear in the same cycle.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      start_bit_out <= 1'h0;
      stop_bit_out <= 1'h0;
      tx_data_empty_flag_out <= 1'h0;
      nack_irq_flag_out <= 1'h0;
      ack_out <= 1'h0;
      irq_out <= 1'h0;
    end else begin
      start_bit_out <= start_set_in || (start_bit && !ev_started);
      stop_bit_out <= stop_set_in || (stop_bit && !ev_stopped);
      tx_data_empty_flag_out <= tx_data_empty_flag_set || (tx_data_empty_flag_out && !wr_take);
      nack_irq_flag_out <= ev_nack || (nack_irq_flag_out && !ev_stopped);
      ack_out <= ev_ack_slot ? !sda_in : ack_out;
      irq_out <= next_irq;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      scl_out <= LINE_LOW;
      sda_out <= LINE_LOW;
      scl_oe_n_out <= LINE_REL;
      sda_oe_n_out <= LINE_REL;
      busy_out <= 1'h0;
    end else begin
      scl_out <= LINE_LOW;
      sda_out <= LINE_LOW;
      scl_oe_n_out <= next_lines.scl;
      sda_oe_n_out <= next_lines.sda;
      busy_out <= next_state != ST_IDLE;
    end
  end

  a_irq_follows_tx_data_empty_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    en && transmit_irq_enable_in && tx_data_empty_flag_out |=> irq_out)
    else $error("interrupt missing while transmit-empty is enabled");

  a_write_clears_tx_data_empty_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_take |=> !tx_data_empty_flag_out)
    else $error("data write did not clear transmit-empty");

  a_first_bit_tx_data_empty_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    ev_first && !fifo_has && !wr_take |=> tx_data_empty_flag_out)
    else $error("transmit-empty not raised after first bit");

  a_ack_tracks_sda: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_ACK && ph == PH_RISE && tick && en |=> ack_out == !$past(sda_in))
    else $error("acknowledge bit does not follow sampled SDA");

  a_nack_needs_free: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(nack_irq_flag_out) |-> $past(state == ST_ACK && !end_pending && scl_oe_n_out))
    else $error("nack flag raised with stop or start pending");

  sequence stop_done_s;
    state == ST_STOP && ph == PH_LAST && tick && en && !stop_set_in;
  endsequence

  a_stop_clears_bits: assert property (@(posedge mclk_in) disable iff (rst_in)
    stop_done_s |=> !stop_bit_out && !nack_irq_flag_out && sda_oe_n_out && scl_oe_n_out)
    else $error("stop did not release lines or clear its bits");

  a_start_needs_data: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_START && $past(state) == ST_IDLE |-> $past(start_bit && fifo_valid))
    else $error("START begun without start bit and data");

  a_stall_holds_scl: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_ACK && ph == PH_FALL && !fifo_has && !end_pending && en
      |=> state == ST_ACK && !scl_oe_n_out)
    else $error("acknowledge clock not stalled while data is missing");

  a_sda_stable_high: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == ST_BIT && scl_oe_n_out && $past(scl_oe_n_out) |-> $stable(sda_oe_n_out))
    else $error("SDA changed while SCL high during a byte");

endmodule // i2c_master_write_sequencer

// ---- design/i2c_wseq_pkg.sv ----
package i2c_wseq_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 10000;
  // Each SCL period is split into four quarter phases.
  localparam int QUARTERS = 4;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (QUARTERS * CLK_PERIOD_NS);
  localparam int BYTE_BITS = 8;
  localparam int TX_FIFO_DEPTH = 8;

  localparam logic [1:0] PH_FALL = 2'h0;
  localparam logic [1:0] PH_SET = 2'h1;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;
  localparam logic LINE_LOW = 1'h0;
  localparam logic LINE_REL = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_ACK,
    ST_HOLD,
    ST_STOP,
    ST_RESTART
  } seq_state_t;

  // Levels that the block lets the two bus lines take; low means pulled down.
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  localparam bus_lines_t LINES_IDLE = '{scl: 1'h1, sda: 1'h1};

endpackage

// ---- design/tx_fifo.sv ----
`timescale 1ns/100ps
module tx_fifo import i2c_wseq_pkg::*; #(
  parameter int WIDTH = BYTE_BITS,
  parameter int DEPTH = TX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  // Control and level
  input wire logic flush_in,
  output logic has_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("tx_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign next_count = count + CW'(push) - CW'(pop);

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
    out_data_out <= mem[rd_ptr];
  end

  // The output stage lags the array by one cycle, so valid drops for a
  // cycle after each pop while the next word comes through.
  always_ff @(posedge mclk_in) begin
    if (rst_in || flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'h1;
      out_valid_out <= 1'h0;
      has_data_out <= 1'h0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_out <= next_count != CW'(DEPTH);
      out_valid_out <= (count != '0) && !pop;
      has_data_out <= next_count != '0;
    end
  end

endmodule // tx_fifo

// ---- design/scl_quarter_tick.sv ----
`timescale 1ns/100ps
module scl_quarter_tick import i2c_wseq_pkg::*; #(
  parameter int CYCLES = QTR_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Run and tick
  input wire logic run_in,
  output logic tick_out
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 2) begin : g_bad_cycles
    $error("scl_quarter_tick: CYCLES must be at least 2");
  end

  logic [CW-1:0] count;
  wire at_end = count == CW'(CYCLES - 1);

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in) begin
      count <= '0;
      tick_out <= 1'h0;
    end else begin
      count <= at_end ? '0 : count + CW'(1);
      tick_out <= at_end;
    end
  end

endmodule // scl_quarter_tick

// ---- verification/i2c_slave_model.sv ----
`timescale 1ns/100ps
module i2c_slave_model (
  // Bus lines as seen on the wires
  input wire logic scl_in,
  input wire logic sda_in,
  // Byte of the frame to refuse, 8'hff for none
  input wire logic [7:0] nack_at_in,
  // Pull on SDA and what was seen
  output logic sda_pull_out,
  output logic [7:0] seen_out [16],
  output int bytes_out,
  output int starts_out,
  output int stops_out
);
  logic [7:0] shift;
  logic [7:0] frame_byte;
  int bits;
  initial begin
    sda_pull_out = 1'h0;
    shift = 8'h00;
    frame_byte = 8'h00;
    bits = 0;
    bytes_out = 0;
    starts_out = 0;
    stops_out = 0;
  end
  always @(negedge sda_in) begin
    if (scl_in === 1'h1) begin
      starts_out++;
      bits = 0;
      frame_byte = 8'h00;
    end
  end
  always @(posedge sda_in) begin
    if (scl_in === 1'h1) begin
      stops_out++;
    end
  end
  always @(posedge scl_in) begin
    if (bits < 8) begin
      shift = {shift[6:0], sda_in};
      bits++;
    end
  end
  // The acknowledge is held for exactly one SCL low-high-low span.
  always @(negedge scl_in) begin
    if (bits == 8) begin
      seen_out[bytes_out % 16] = shift;
      bytes_out++;
      sda_pull_out = (frame_byte != nack_at_in);
      frame_byte++;
      bits = 9;
    end else if (bits == 9) begin
      sda_pull_out = 1'h0;
      bits = 0;
    end
  end
endmodule // i2c_slave_model

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top import i2c_wseq_pkg::*;;
  logic mclk_in, rst_in, en, txie, st, sp, fl, tx_wr_in, tx_ready_out;
  logic [7:0] tx_data_in;
  logic start_bit_out, stop_bit_out, tx_data_empty_flag, nack_irq_flag_out, ack_out, busy_out, irq_out;
  logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, sda_pull, nack_seen;
  logic [7:0] nack_at;
  logic [7:0] seen [16];
  int bytes_out, starts_out, stops_out, b0, s0, p0;
  int fail_count = 0;
  int compares = 0;
  wire logic scl = scl_oe_n_out ? 1'h1 : scl_out;
  wire logic sda = (sda_oe_n_out ? 1'h1 : sda_out) & ~sda_pull;
  i2c_master_write_sequencer #(.QTR(4), .DEPTH(TX_FIFO_DEPTH)) dut (.mclk_in(mclk_in),
    .rst_in(rst_in), .controller_enable_bit_in(en), .transmit_irq_enable_in(txie),
    .start_set_in(st), .stop_set_in(sp), .flush_set_in(fl), .tx_wr_in(tx_wr_in),
    .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .start_bit_out(start_bit_out),
    .stop_bit_out(stop_bit_out), .tx_data_empty_flag_out(tx_data_empty_flag),
    .nack_irq_flag_out(nack_irq_flag_out), .ack_out(ack_out), .busy_out(busy_out),
    .irq_out(irq_out), .scl_in(scl), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out));
  i2c_slave_model slave (.scl_in(scl), .sda_in(sda), .nack_at_in(nack_at),
    .sda_pull_out(sda_pull), .seen_out(seen), .bytes_out(bytes_out),
    .starts_out(starts_out), .stops_out(stops_out));
  initial begin
    mclk_in = 1'h0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (nack_irq_flag_out === 1'h1) begin
      nack_seen <= 1'h1;
    end
  end
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input string what);
    int n;
    n = 0;
    while (s !== v && n < 4000) begin
      @(negedge mclk_in);
      n++;
    end
    check(what, v, s);
  endtask
  task automatic wr(input logic [7:0] b);
    tx_data_in = b;
    tx_wr_in = 1'h1;
    @(negedge mclk_in);
    tx_wr_in = 1'h0;
    check("tx_data_empty_flag after write", 1'h0, tx_data_empty_flag);
  endtask
  task automatic pulse(input logic a, input logic b, input logic c);
    st = a;
    sp = b;
    fl = c;
    @(negedge mclk_in);
    st = 1'h0;
    sp = 1'h0;
    fl = 1'h0;
  endtask
  task automatic mark();
    b0 = bytes_out;
    s0 = starts_out;
    p0 = stops_out;
    nack_seen = 1'h0;
  endtask
  task automatic frame(input int nb, input int ns, input int np);
    check("bytes on bus", nb, bytes_out - b0);
    check("starts on bus", ns, starts_out - s0);
    check("stops on bus", np, stops_out - p0);
  endtask
  task automatic seen_is(input int i, input logic [7:0] e);
    check("byte on bus", e, seen[(b0 + i) % 16]);
  endtask
  task automatic t_reset();
    check("busy at reset", 1'h0, busy_out);
    check("ready at reset", 1'h1, tx_ready_out);
    check("lines released", 2'h3, {scl_oe_n_out, sda_oe_n_out});
    en = 1'h1;
    txie = 1'h1;
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag when enabled");
    @(negedge mclk_in);
    check("irq when empty", 1'h1, irq_out);
  endtask
  task automatic t_write7();
    mark();
    nack_at = 8'h01;
    wr(8'ha4);
    pulse(1'h1, 1'h0, 1'h0);
    check("start bit set", 1'h1, start_bit_out);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag after first bit");
    repeat (300) @(negedge mclk_in);
    check("stall scl low", 1'h0, scl);
    check("stall bytes", 1, bytes_out - b0);
    check("stall ack", 1'h0, ack_out);
    check("busy in stall", 1'h1, busy_out);
    wr(8'h5c);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag data");
    check("address ack", 1'h1, ack_out);
    txie = 1'h0;
    pulse(1'h0, 1'h1, 1'h0);
    wait_for(stop_bit_out, 1'h0, "stop cleared");
    frame(2, 1, 1);
    seen_is(0, 8'ha4);
    seen_is(1, 8'h5c);
    check("no nack last", 1'h0, nack_seen);
    check("last ack refused", 1'h0, ack_out);
    check("idle after stop", 1'h0, busy_out);
    nack_at = 8'hff;
  endtask
  task automatic t_nack(input logic [7:0] at);
    logic [7:0] q [3];
    q = '{8'hf4, 8'h3a, 8'h81};
    mark();
    nack_at = at;
    txie = 1'h1;
    wr(q[0]);
    pulse(1'h1, 1'h0, 1'h0);
    for (int i = 1; i <= at + 1; i++) begin
      wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag next");
      wr(q[i]);
    end
    wait_for(nack_irq_flag_out, 1'h1, "nack flag");
    check("ack on nack", 1'h0, ack_out);
    @(negedge mclk_in);
    check("irq on nack", 1'h1, irq_out);
    txie = 1'h0;
    pulse(1'h0, 1'h1, 1'h1);
    wait_for(stop_bit_out, 1'h0, "stop after nack");
    check("nack cleared", 1'h0, nack_irq_flag_out);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag after flush");
    frame(at + 1, 1, 1);
    nack_at = 8'hff;
  endtask
  task automatic t_probe(input logic nk);
    mark();
    nack_at = nk ? 8'h00 : 8'hff;
    txie = 1'h1;
    wr(8'ha4);
    txie = 1'h0;
    pulse(1'h1, 1'h1, 1'h0);
    check("probe stop set", 1'h1, stop_bit_out);
    wait_for(tx_data_empty_flag, 1'h1, "probe tx_data_empty_flag");
    check("probe stop held", 1'h1, stop_bit_out);
    wait_for(stop_bit_out, 1'h0, "probe stop done");
    check("probe ack", !nk, ack_out);
    check("probe no nack", 1'h0, nack_seen);
    frame(1, 1, 1);
    nack_at = 8'hff;
  endtask
  task automatic t_tenbit();
    mark();
    txie = 1'h1;
    wr(8'hf4);
    pulse(1'h1, 1'h0, 1'h0);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag first address");
    wr(8'h3a);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag second address");
    wr(8'h81);
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag ten bit data");
    pulse(1'h1, 1'h0, 1'h0);
    wr(8'h42);
    wait_for(start_bit_out, 1'h0, "restart done");
    wait_for(tx_data_empty_flag, 1'h1, "tx_data_empty_flag after restart");
    txie = 1'h0;
    pulse(1'h0, 1'h1, 1'h0);
    wait_for(stop_bit_out, 1'h0, "ten bit stop");
    frame(4, 2, 1);
    seen_is(0, 8'hf4);
    seen_is(1, 8'h3a);
    seen_is(2, 8'h81);
    seen_is(3, 8'h42);
    check("ten bit no nack", 1'h0, nack_seen);
  endtask
  task automatic t_fill();
    mark();
    txie = 1'h1;
    tx_wr_in = 1'h1;
    for (int i = 0; i < 9; i++) begin
      tx_data_in = (i == 0) ? 8'ha4 : 8'(i);
      @(negedge mclk_in);
      if (i == 7) begin
        check("fifo full", 1'h0, tx_ready_out);
      end
    end
    tx_wr_in = 1'h0;
    pulse(1'h1, 1'h0, 1'h0);
    wait_for(tx_data_empty_flag, 1'h1, "fifo drained");
    txie = 1'h0;
    pulse(1'h0, 1'h1, 1'h0);
    wait_for(stop_bit_out, 1'h0, "burst stop");
    frame(8, 1, 1);
    for (int i = 0; i < 8; i++) begin
      seen_is(i, (i == 0) ? 8'ha4 : 8'(i));
    end
    wr(8'h55);
    repeat (50) @(negedge mclk_in);
    check("no start without bit", 1, starts_out - s0);
    pulse(1'h0, 1'h0, 1'h1);
    wait_for(tx_data_empty_flag, 1'h1, "flush empties");
    check("ready after flush", 1'h1, tx_ready_out);
  endtask
  initial begin
    rst_in = 1'h1;
    {en, txie, st, sp, fl, tx_wr_in, nack_seen} = 7'h00;
    tx_data_in = 8'h00;
    nack_at = 8'hff;
    repeat (6) @(negedge mclk_in);
    rst_in = 1'h0;
    t_reset();
    t_write7();
    t_nack(8'h00);
    t_nack(8'h01);
    t_probe(1'h0);
    t_probe(1'h1);
    t_tenbit();
    t_fill();
    report_and_stop();
  end
  initial begin
    #300000;
    fail_count++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    report_and_stop();
  end
endmodule // tb_top
